// ---- shared/shift_test_branch_defs.svh ----
// Opcodes, field positions, reset values and step sizes of the shift/test/branch unit
`ifndef SHIFT_TEST_BRANCH_DEFS_SVH
`define SHIFT_TEST_BRANCH_DEFS_SVH

// Shift group
`define OP_LOGICAL_SHIFT 8'h64
`define OP_ARITH_SHIFT 8'h60
`define OP_ROTATE_SHIFT 8'h6C

// Test-and-modify group: high nibble picks set or clear
`define NIB_MOD_SET 4'hD
`define NIB_MOD_CLEAR 4'h9
`define BIT_MOD_RIGHT 2
`define BIT_MOD_ANY_ONE 3

// Test-and-branch and index group
`define NIB_TB_PROC 4'hB
`define NIB_TB_COMM 4'hA
`define BIT_INCDEC_NONZERO 2
`define BIT_INCDEC_DEC 3
`define LOW_INDEX_FORM 2'h2
`define COND_ZERO 2'h0
`define COND_NONZERO 2'h1
`define COND_NONNEG 2'h2
`define COND_NEGATIVE 2'h3
`define WID_WORD 2'h0
`define WID_HALF 2'h1

// Branch and save
`define OP_RELATIVE_SAVE 8'hAE
`define OP_BASE_SAVE 8'h12
`define SAVE_SRC_BIT 31

// Field positions
`define SHIFT_CNT_MSB 5
`define COMM_ADDR_MSB 5
`define HALF_MSB 15
`define BYTE_MSB 7

// Program counter steps and reset
`define PC_STEP 16'h0001
`define PC_SKIP_STEP 16'h0002
`define HALF_STEP 16'h0001
`define PC_RST 16'h0000

`endif

// ---- shared/shift_test_branch_pkg.sv ----
// Types shared by the shift/test/branch unit and its surroundings
package shift_test_branch_pkg;
   typedef struct packed {
      logic [7:0] opcode;
      logic [3:0] r_field;
      logic [31:0] imm;
      logic [15:0] pc;
      logic [15:0] target;
      logic from_central;
   } instr_t;

   typedef struct packed {
      logic wr_en;
      logic [3:0] addr;
      logic [31:0] data;
   } proc_wr_t;

   typedef struct packed {
      logic wr_en;
      logic [5:0] addr;
      logic [31:0] data;
   } comm_wr_t;

   typedef struct packed {
      logic [15:0] next_pc;
      logic skip;
      logic branch;
   } pc_upd_t;

   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_RESP} state_t;

   typedef struct packed {
      state_t state;
      instr_t instr;
      logic [31:0] operand;
      proc_wr_t pwr;
      comm_wr_t cwr;
      pc_upd_t pcu;
      logic done;
   } core_t;
endpackage : shift_test_branch_pkg

// ---- design/shift_test_branch_exec.sv ----
// Execution unit for shift, test-and-modify, test-and-branch and save-branch instructions
//
// Summary of operation
// - Shift count: low six immediate bits, signed
// - Arithmetic right shift replicates top bit
// - Cyclic shift rotates bits end to end
// - R field masks left or right half
// - D2/D6: skip on masked zero, set mask
// - DA/DE: skip on masked one, set mask
// - 92/96: skip on masked zero, clear mask
// - 9A/9E: skip on masked one, clear mask
// - Skip advances program counter by two
// - B opcodes read proc, A read comm
// - Branch when selected width equals zero
// - Branch when selected width is nonzero
// - Branch when signed value not negative
// - Branch when signed value is negative
// - B2: increment halfword, branch if zero
// - B6: increment halfword, branch if nonzero
// - BA: decrement halfword, branch if zero
// - BE: decrement halfword, branch if nonzero
// - AE saves PC plus one, source bit
// - Base-relative save stores the same way
// - Logical shift fills vacated bits with zeros
`include "shift_test_branch_defs.svh"

module shift_test_branch_exec (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_instr_valid,
   input wire shift_test_branch_pkg::instr_t i_instr,
   input wire logic [31:0] i_proc_rd_data,
   input wire logic [31:0] i_comm_rd_data,
   output logic o_ready,
   output logic [3:0] o_proc_rd_addr,
   output logic [5:0] o_comm_rd_addr,
   output shift_test_branch_pkg::proc_wr_t o_proc_wr,
   output shift_test_branch_pkg::comm_wr_t o_comm_wr,
   output shift_test_branch_pkg::pc_upd_t o_pc_upd,
   output logic o_done
);
   shift_test_branch_pkg::core_t c_r;
   shift_test_branch_pkg::core_t c_nxt;

   function automatic logic is_shift(input logic [7:0] op);
      is_shift = (op == `OP_LOGICAL_SHIFT) || (op == `OP_ARITH_SHIFT) ||
         (op == `OP_ROTATE_SHIFT);
   endfunction : is_shift

   function automatic logic is_testmod(input logic [7:0] op);
      is_testmod = (op[1:0] == `LOW_INDEX_FORM) &&
         ((op[7:4] == `NIB_MOD_SET) || (op[7:4] == `NIB_MOD_CLEAR));
   endfunction : is_testmod

   function automatic logic is_incdec(input logic [7:0] op);
      is_incdec = (op[7:4] == `NIB_TB_PROC) && (op[1:0] == `LOW_INDEX_FORM);
   endfunction : is_incdec

   function automatic logic is_save(input logic [7:0] op);
      is_save = (op == `OP_RELATIVE_SAVE) || (op == `OP_BASE_SAVE);
   endfunction : is_save

   function automatic logic is_testbr(input logic [7:0] op);
      is_testbr = ((op[7:4] == `NIB_TB_PROC) || (op[7:4] == `NIB_TB_COMM)) &&
         (op[1:0] != `LOW_INDEX_FORM);
   endfunction : is_testbr

   // Comm register address: operand field for test-and-modify, R field for A forms
   function automatic logic [5:0] comm_addr(input shift_test_branch_pkg::instr_t ins);
      if (is_testmod(ins.opcode)) begin
         comm_addr = ins.imm[`COMM_ADDR_MSB:0];
      end else begin
         comm_addr = {2'h0, ins.r_field};
      end
   endfunction : comm_addr

   function automatic logic [31:0] shift_fn(input logic [31:0] v, input logic [5:0] cnt,
         input logic [7:0] op);
      logic [63:0] ext;
      logic [5:0] mag;
      ext = '0;
      mag = 6'(-cnt);
      if (op == `OP_ROTATE_SHIFT) begin
         // Left rotate by the low five bits covers negative counts too (mod 32)
         ext = {v, v} << cnt[4:0];
         shift_fn = ext[63:32];
      end else if (!cnt[5]) begin
         shift_fn = v << cnt[4:0];
      end else begin
         // 64-bit extension lets a count of -32 clear or fill the whole word
         ext = {{32{v[31] & (op == `OP_ARITH_SHIFT)}}, v} >> mag;
         shift_fn = ext[31:0];
      end
   endfunction : shift_fn

   // Returns {negative, zero} of the word, low halfword or low byte
   function automatic logic [1:0] width_test(input logic [31:0] v, input logic [1:0] wid);
      case (wid)
         `WID_WORD: width_test = {v[31], v == 32'h0000_0000};
         `WID_HALF: width_test = {v[`HALF_MSB], v[`HALF_MSB:0] == 16'h0000};
         default: width_test = {v[`BYTE_MSB], v[`BYTE_MSB:0] == 8'h00};
      endcase
   endfunction : width_test

   logic [7:0] op;
   logic [31:0] opnd;
   logic [3:0] half;
   logic [3:0] new_half;
   logic [15:0] hw;
   logic [1:0] nz;
   logic take;

   always_comb begin
      c_nxt = c_r;
      c_nxt.done = 1'b0;
      c_nxt.pwr.wr_en = 1'b0;
      c_nxt.cwr.wr_en = 1'b0;
      op = c_r.instr.opcode;
      opnd = 32'h0000_0000;
      half = 4'h0;
      new_half = 4'h0;
      hw = 16'h0000;
      nz = 2'h0;
      take = 1'b0;
      case (c_r.state)
         shift_test_branch_pkg::ST_IDLE: begin
            if (i_instr_valid) begin
               c_nxt.instr = i_instr;
               c_nxt.state = shift_test_branch_pkg::ST_READ;
            end
         end
         shift_test_branch_pkg::ST_READ: begin
            if (is_testmod(op) || (op[7:4] == `NIB_TB_COMM && is_testbr(op))) begin
               opnd = i_comm_rd_data;
            end else begin
               opnd = i_proc_rd_data;
            end
            c_nxt.operand = opnd;
            c_nxt.pwr.addr = c_r.instr.r_field;
            c_nxt.pwr.data = opnd;
            c_nxt.cwr.addr = comm_addr(c_r.instr);
            c_nxt.cwr.data = opnd;
            c_nxt.pcu.next_pc = c_r.instr.pc + `PC_STEP;
            c_nxt.pcu.skip = 1'b0;
            c_nxt.pcu.branch = 1'b0;
            if (is_shift(op)) begin
               c_nxt.pwr.wr_en = 1'b1;
               c_nxt.pwr.data = shift_fn(opnd, c_r.instr.imm[`SHIFT_CNT_MSB:0], op);
            end else if (is_testmod(op)) begin
               half = op[`BIT_MOD_RIGHT] ? opnd[3:0] : opnd[7:4];
               // Test is on the old contents; the write-back reaches the register one cycle after the result
               if (op[`BIT_MOD_ANY_ONE]) begin
                  take = |(c_r.instr.r_field & half);
               end else begin
                  take = |(c_r.instr.r_field & ~half);
               end
               if (op[7:4] == `NIB_MOD_SET) begin
                  new_half = half | c_r.instr.r_field;
               end else begin
                  new_half = half & ~c_r.instr.r_field;
               end
               c_nxt.cwr.wr_en = 1'b1;
               if (op[`BIT_MOD_RIGHT]) begin
                  c_nxt.cwr.data = {opnd[31:4], new_half};
               end else begin
                  c_nxt.cwr.data = {opnd[31:8], new_half, opnd[3:0]};
               end
               if (take) begin
                  c_nxt.pcu.skip = 1'b1;
                  c_nxt.pcu.next_pc = c_r.instr.pc + `PC_SKIP_STEP;
               end
            end else if (is_incdec(op)) begin
               if (op[`BIT_INCDEC_DEC]) begin
                  hw = opnd[`HALF_MSB:0] - `HALF_STEP;
               end else begin
                  hw = opnd[`HALF_MSB:0] + `HALF_STEP;
               end
               c_nxt.pwr.wr_en = 1'b1;
               c_nxt.pwr.data = {opnd[31:16], hw};
               take = (hw == 16'h0000) ^ op[`BIT_INCDEC_NONZERO];
               if (take) begin
                  c_nxt.pcu.branch = 1'b1;
                  c_nxt.pcu.next_pc = c_r.instr.target;
               end
            end else if (is_save(op)) begin
               c_nxt.pwr.wr_en = 1'b1;
               c_nxt.pwr.data = 32'h0000_0000;
               c_nxt.pwr.data[15:0] = c_r.instr.pc + `PC_STEP;
               c_nxt.pwr.data[`SAVE_SRC_BIT] = c_r.instr.from_central;
               c_nxt.pcu.branch = 1'b1;
               c_nxt.pcu.next_pc = c_r.instr.target;
            end else if (is_testbr(op)) begin
               nz = width_test(opnd, op[1:0]);
               case (op[3:2])
                  `COND_ZERO: take = nz[0];
                  `COND_NONZERO: take = !nz[0];
                  `COND_NONNEG: take = !nz[1];
                  default: take = nz[1];
               endcase
               if (take) begin
                  c_nxt.pcu.branch = 1'b1;
                  c_nxt.pcu.next_pc = c_r.instr.target;
               end
            end
            c_nxt.done = 1'b1;
            c_nxt.state = shift_test_branch_pkg::ST_RESP;
         end
         shift_test_branch_pkg::ST_RESP: begin
            c_nxt.state = shift_test_branch_pkg::ST_IDLE;
         end
         default: begin
            c_nxt.state = shift_test_branch_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         c_r <= '0;
      end else begin
         c_r <= c_nxt;
      end
   end

   // Ready and the comm read address are decoded from the state flops; everything else comes straight from them
   assign o_ready = (c_r.state == shift_test_branch_pkg::ST_IDLE);
   assign o_proc_rd_addr = c_r.instr.r_field;
   assign o_comm_rd_addr = comm_addr(c_r.instr);
   assign o_proc_wr = c_r.pwr;
   assign o_comm_wr = c_r.cwr;
   assign o_pc_upd = c_r.pcu;
   assign o_done = c_r.done;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   logic [7:0] r_op;
   assign r_op = c_r.instr.opcode;

   sequence s_accept;
      o_ready && i_instr_valid;
   endsequence

   sequence s_result;
      !o_ready ##1 o_done;
   endsequence

   property p_latency;
      s_accept |=> s_result;
   endproperty
   a_latency: assert property (p_latency) else $error("Result not two cycles after accept");

   property p_skip_step;
      o_done && o_pc_upd.skip |-> o_pc_upd.next_pc == c_r.instr.pc + 16'h0002;
   endproperty
   a_skip_step: assert property (p_skip_step) else $error("Skip did not add two");

   property p_seq_step;
      o_done && !o_pc_upd.skip && !o_pc_upd.branch |->
         o_pc_upd.next_pc == c_r.instr.pc + 16'h0001;
   endproperty
   a_seq_step: assert property (p_seq_step) else $error("Sequential step not one");

   property p_testmod_skip;
      o_done && is_testmod(r_op) |->
         o_comm_wr.wr_en && (o_pc_upd.skip == (r_op[3] ?
         |(c_r.instr.r_field & (r_op[2] ? c_r.operand[3:0] : c_r.operand[7:4])) :
         |(c_r.instr.r_field & ~(r_op[2] ? c_r.operand[3:0] : c_r.operand[7:4]))));
   endproperty
   a_testmod_skip: assert property (p_testmod_skip) else $error("Test skip wrong");

   property p_testmod_mask;
      o_done && is_testmod(r_op) && r_op[7:4] == 4'hD && !r_op[2] |->
         (o_comm_wr.data[7:4] & c_r.instr.r_field) == c_r.instr.r_field;
   endproperty
   a_testmod_mask: assert property (p_testmod_mask) else $error("Mask bits not set");

   property p_rotate;
      o_done && r_op == 8'h6C && c_r.instr.imm[5:0] == 6'h3F |->
         o_proc_wr.data == {c_r.operand[0], c_r.operand[31:1]};
   endproperty
   a_rotate: assert property (p_rotate) else $error("Rotate right by one wrong");

   property p_arith_right;
      o_done && r_op == 8'h60 && c_r.instr.imm[5] |->
         o_proc_wr.data[31] == c_r.operand[31] && o_proc_wr.data[30] == c_r.operand[31];
   endproperty
   a_arith_right: assert property (p_arith_right) else $error("Sign not kept");

   property p_incdec;
      o_done && is_incdec(r_op) |-> o_proc_wr.wr_en &&
         o_proc_wr.data[15:0] == (r_op[3] ? c_r.operand[15:0] - 16'h0001 :
         c_r.operand[15:0] + 16'h0001) && o_pc_upd.branch == (r_op[2] ^
         (o_proc_wr.data[15:0] == 16'h0000));
   endproperty
   a_incdec: assert property (p_incdec) else $error("Index modify wrong");

   property p_save;
      o_done && is_save(r_op) |-> o_pc_upd.branch &&
         o_proc_wr.data[31] == c_r.instr.from_central &&
         o_proc_wr.data[15:0] == c_r.instr.pc + 16'h0001 &&
         o_pc_upd.next_pc == c_r.instr.target;
   endproperty
   a_save: assert property (p_save) else $error("Save branch wrong");

   property p_negative;
      o_done && r_op == 8'hBF |-> o_pc_upd.branch == c_r.operand[7];
   endproperty
   a_negative: assert property (p_negative) else $error("Byte negative test wrong");

   property p_mod_keep;
      o_done && is_testmod(r_op) |-> o_comm_wr.data[31:8] == c_r.operand[31:8] &&
         (r_op[2] ? o_comm_wr.data[7:4] == c_r.operand[7:4] :
         o_comm_wr.data[3:0] == c_r.operand[3:0]);
   endproperty
   a_mod_keep: assert property (p_mod_keep) else $error("Untouched bits changed");

   property p_mod_clear;
      o_done && is_testmod(r_op) && r_op[7:4] == 4'h9 |->
         ((r_op[2] ? o_comm_wr.data[3:0] : o_comm_wr.data[7:4]) & c_r.instr.r_field) == 4'h0;
   endproperty
   a_mod_clear: assert property (p_mod_clear) else $error("Mask bits not cleared");

   property p_set_right;
      o_done && is_testmod(r_op) && r_op[7:4] == 4'hD && r_op[2] |->
         (o_comm_wr.data[3:0] & c_r.instr.r_field) == c_r.instr.r_field;
   endproperty
   a_set_right: assert property (p_set_right) else $error("Right mask not set");

   property p_zero_fill;
      o_done && r_op == 8'h64 && c_r.instr.imm[5] |-> !o_proc_wr.data[31];
   endproperty
   a_zero_fill: assert property (p_zero_fill) else $error("Zero fill missing");

   property p_shift_four;
      o_done && r_op == 8'h60 && c_r.instr.imm[5:0] == 6'h04 |->
         o_proc_wr.data == {c_r.operand[27:0], 4'h0};
   endproperty
   a_shift_four: assert property (p_shift_four) else $error("Shift by four wrong");

   property p_zero_word;
      o_done && (r_op == 8'hB0 || r_op == 8'hA0) |->
         o_pc_upd.branch == (c_r.operand == 32'h0000_0000);
   endproperty
   a_zero_word: assert property (p_zero_word) else $error("Word zero test wrong");

   property p_half_nonzero;
      o_done && r_op == 8'hB5 |-> o_pc_upd.branch == (c_r.operand[15:0] != 16'h0000);
   endproperty
   a_half_nonzero: assert property (p_half_nonzero) else $error("Half nonzero wrong");

   property p_half_nonneg;
      o_done && r_op == 8'hB9 |-> o_pc_upd.branch == !c_r.operand[15];
   endproperty
   a_half_nonneg: assert property (p_half_nonneg) else $error("Half sign wrong");
endmodule : shift_test_branch_exec

// ---- verif/reg_file_model.sv ----
// Behavioural processor and communication register files for the execution unit
module reg_file_model (
   input wire logic i_sys_clk,
   input wire logic [3:0] i_proc_rd_addr,
   input wire logic [5:0] i_comm_rd_addr,
   input wire shift_test_branch_pkg::proc_wr_t i_proc_wr,
   input wire shift_test_branch_pkg::comm_wr_t i_comm_wr,
   output logic [31:0] o_proc_rd_data,
   output logic [31:0] o_comm_rd_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] pr [16];
   logic [31:0] comm_mem [64];
   initial begin
      for (int i = 0; i < 64; i++) begin
         comm_mem[i] = 32'h0;
         pr[i % 16] = 32'h0;
      end
   end
   // Same-cycle reads: the unit samples read data on the edge after accept
   assign o_proc_rd_data = pr[i_proc_rd_addr];
   assign o_comm_rd_data = comm_mem[i_comm_rd_addr];
   // Plain always so the bench may preload contents between instructions
   always @(posedge i_sys_clk) begin
      if (i_proc_wr.wr_en) begin
         pr[i_proc_wr.addr] <= i_proc_wr.data;
      end
      if (i_comm_wr.wr_en) begin
         comm_mem[i_comm_wr.addr] <= i_comm_wr.data;
      end
   end
endmodule : reg_file_model

// ---- verif/testbench.sv ----
// Self-checking testbench for the shift/test/branch execution unit
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] PC = 16'h0100;
   localparam logic [15:0] TGT = 16'h0800;
   logic i_sys_clk;
   logic i_rst;
   logic instr_valid;
   shift_test_branch_pkg::instr_t instr;
   logic ready;
   logic done;
   logic [3:0] proc_rd_addr;
   logic [5:0] comm_rd_addr;
   logic [31:0] proc_rd_data;
   logic [31:0] comm_rd_data;
   shift_test_branch_pkg::proc_wr_t proc_wr;
   shift_test_branch_pkg::comm_wr_t comm_wr;
   shift_test_branch_pkg::pc_upd_t pc_upd;
   shift_test_branch_pkg::pc_upd_t got_pc;
   int num_errors;
   int num_checks;

   shift_test_branch_exec dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_instr_valid(instr_valid), .i_instr(instr), .i_proc_rd_data(proc_rd_data),
      .i_comm_rd_data(comm_rd_data), .o_ready(ready), .o_proc_rd_addr(proc_rd_addr),
      .o_comm_rd_addr(comm_rd_addr), .o_proc_wr(proc_wr), .o_comm_wr(comm_wr),
      .o_pc_upd(pc_upd), .o_done(done));

   reg_file_model rf (.i_sys_clk(i_sys_clk), .i_proc_rd_addr(proc_rd_addr),
      .i_comm_rd_addr(comm_rd_addr), .i_proc_wr(proc_wr), .i_comm_wr(comm_wr),
      .o_proc_rd_data(proc_rd_data), .o_comm_rd_data(comm_rd_data));

   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_pc(input logic [15:0] exp);
      chk({16'h0, got_pc.next_pc}, {16'h0, exp});
      // Skip and branch flags follow from where the program counter must go
      chk({30'h0, got_pc.skip, got_pc.branch},
          {30'h0, exp == PC + 16'h0002, exp == TGT});
   endtask : chk_pc

   // One instruction: offer, wait for the accept edge, then for the result pulse
   task automatic run(input logic [7:0] op, input logic [3:0] r, input logic [31:0] imm,
                      input logic central);
      int n;
      instr = '{opcode: op, r_field: r, imm: imm, pc: PC, target: TGT, from_central: central};
      instr_valid = 1'b1;
      n = 0;
      while (ready !== 1'b1 && n < 8) begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end
      chk({31'h0, ready}, 32'h1);
      @(posedge i_sys_clk);
      #1;
      instr_valid = 1'b0;
      while (done !== 1'b1 && n < 16) begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end
      if (n >= 16) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, done, 1'b1);
         give_verdict();
      end
      got_pc = pc_upd;
      chk({31'h0, ready}, 32'h0);
      // Let the register write land before the caller looks
      @(posedge i_sys_clk);
      #1;
      // The result pulse lasts one cycle only
      chk({31'h0, done}, 32'h0);
   endtask : run

   task automatic test_shifts;
      logic [7:0] ops [8] = '{8'h60, 8'h60, 8'h60, 8'h6C, 8'h6C, 8'h64, 8'h64, 8'h64};
      logic [5:0] cnt [8] = '{6'h3C, 6'h04, 6'h20, 6'h04, 6'h3C, 6'h3F, 6'h1F, 6'h20};
      logic [31:0] exp [8] = '{32'hF800_000F, 32'h0000_0F10, 32'hFFFF_FFFF, 32'h0000_0F18,
                               32'h1800_000F, 32'h4000_0078, 32'h8000_0000, 32'h0000_0000};
      for (int i = 0; i < 8; i++) begin
         rf.pr[1] = 32'h8000_00F1;
         // Upper immediate bits set so only the low six may count
         run(ops[i], 4'h1, {26'h3FF_FFFF, cnt[i]}, 1'b0);
         chk(rf.pr[1], exp[i]);
         chk_pc(PC + 16'h0001);
      end
   endtask : test_shifts

   task automatic test_modify;
      logic [7:0] ops [8] = '{8'hD2, 8'hD6, 8'hDA, 8'hDE, 8'h92, 8'h96, 8'h9A, 8'h9E};
      logic [3:0] masks [3] = '{4'h6, 4'hA, 4'hF};
      logic [3:0] half;
      logic [3:0] nh;
      logic [7:0] b;
      logic skip;
      for (int i = 0; i < 8; i++) begin
         for (int m = 0; m < 3; m++) begin
            b = 8'hA5;
            half = ops[i][2] ? b[3:0] : b[7:4];
            skip = ops[i][3] ? |(masks[m] & half) : |(masks[m] & ~half);
            nh = (ops[i][7:4] == 4'hD) ? (half | masks[m]) : (half & ~masks[m]);
            b = ops[i][2] ? {b[7:4], nh} : {nh, b[3:0]};
            rf.comm_mem[6'h25] = 32'hABCD_12A5;
            run(ops[i], masks[m], 32'h0000_0025, 1'b1);
            chk(rf.comm_mem[6'h25], {24'hABCD12, b});
            chk_pc(PC + (skip ? 16'h0002 : 16'h0001));
         end
      end
   endtask : test_modify

   task automatic test_branch;
      logic [31:0] vals [4] = '{32'h0, 32'h8000_0000, 32'h0000_8000, 32'h0001_0080};
      logic [1:0] wids [3] = '{2'h0, 2'h1, 2'h3};
      logic [7:0] op;
      logic signed [31:0] s;
      logic take;
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 4; c++) begin
            for (int w = 0; w < 3; w++) begin
               for (int v = 0; v < 4; v++) begin
                  op = {(p == 1) ? 4'hA : 4'hB, c[1:0], wids[w]};
                  s = (w == 0) ? vals[v] : (w == 1) ? {{16{vals[v][15]}}, vals[v][15:0]} :
                      {{24{vals[v][7]}}, vals[v][7:0]};
                  case (c)
                     0: take = (s == 0);
                     1: take = (s != 0);
                     2: take = (s >= 0);
                     default: take = (s < 0);
                  endcase
                  // The register not selected holds the inverse, so a wrong source shows
                  rf.pr[3] = (p == 1) ? ~vals[v] : vals[v];
                  rf.comm_mem[3] = (p == 1) ? vals[v] : ~vals[v];
                  run(op, 4'h3, 32'h0, 1'b0);
                  chk_pc(take ? TGT : PC + 16'h0001);
               end
            end
         end
      end
   endtask : test_branch

   task automatic test_index;
      logic [7:0] ops [4] = '{8'hB2, 8'hB6, 8'hBA, 8'hBE};
      logic [31:0] vals [3] = '{32'h1234_FFFF, 32'h1234_0001, 32'h5678_0007};
      logic [15:0] h;
      logic take;
      for (int i = 0; i < 4; i++) begin
         for (int v = 0; v < 3; v++) begin
            h = ops[i][3] ? vals[v][15:0] - 16'h0001 : vals[v][15:0] + 16'h0001;
            take = ops[i][2] ? (h != 16'h0) : (h == 16'h0);
            rf.pr[5] = vals[v];
            run(ops[i], 4'h5, 32'h0, 1'b0);
            chk(rf.pr[5], {vals[v][31:16], h});
            chk_pc(take ? TGT : PC + 16'h0001);
         end
      end
   endtask : test_index

   task automatic test_save;
      logic [7:0] ops [2] = '{8'hAE, 8'h12};
      for (int i = 0; i < 2; i++) begin
         for (int src = 0; src < 2; src++) begin
            rf.pr[7] = 32'h5A5A_5A5A;
            run(ops[i], 4'h7, 32'h0, src[0]);
            chk(rf.pr[7], {src[0], 15'h0, PC + 16'h0001});
            chk_pc(TGT);
         end
      end
   endtask : test_save

   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end

   initial begin
      num_errors = 0;
      num_checks = 0;
      i_rst = 1'b1;
      instr_valid = 1'b0;
      instr = '0;
      repeat (3) @(posedge i_sys_clk);
      #1;
      i_rst = 1'b0;
      chk({31'h0, ready}, 32'h1);
      test_shifts();
      test_modify();
      test_branch();
      test_index();
      test_save();
      give_verdict();
   end
endmodule : testbench
